// ===== verilog/tc_pkg.sv
// Purpose: Shared constants for the second 8-bit timer/counter.
// Assumes: Register indices sit on an AXI4-Lite bus, byte address = 4 * index.
// Notes:   Field positions and reset values are named here and nowhere else.
package tc_pkg;
  // ==========================================================================
  // Register indices and bus geometry.
  // ==========================================================================
  localparam int         ADDR_W  = 12;        // Byte address width.
  localparam logic [9:0] IDX_CFG = 10'h0d8;   // Shared timer configuration.
  localparam logic [9:0] IDX_MOD = 10'h0dc;   // Timer mode register.
  localparam logic [9:0] IDX_CNT = 10'h0dd;   // Count register.
  localparam logic [9:0] IDX_RLD = 10'h0de;   // Reload register, write only.
  localparam logic [9:0] IDX_IRQ = 10'h0e0;   // Enable and request flags.
  localparam logic [1:0] RESP_OK  = 2'h0;     // OKAY answer.
  localparam logic [1:0] RESP_ERR = 2'h2;     // SLVERR answer for holes.
  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CFG_FAST  = 3;               // Fast-source select.
  localparam int MOD_RUN   = 7;               // Timer run bit.
  localparam int MOD_RATE  = 4;               // Divider code, low bit.
  localparam int MOD_EXT   = 3;               // External source bit.
  localparam int MOD_ALOAD = 2;               // Reload enable bit.
  localparam int MOD_TOG   = 1;               // Toggle output bit.
  localparam int MOD_PWM   = 0;               // PWM enable bit.
  localparam int IRQ_EN    = 0;               // Timer interrupt enable.
  localparam int IRQ_FLAG  = 1;               // Timer interrupt request flag.
  localparam int IRQ_PIN   = 2;               // Event pin request flag.
  // ==========================================================================
  // Reset values and divider masks.
  // ==========================================================================
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] MOD_RST  = 8'h00;
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] RLD_RST  = 8'h00;
  localparam logic [7:0] CPU_MASK = 8'hff;    // Code 000 divides by 256.
  localparam logic [7:0] OSC_MASK = 8'h7f;    // Code 000 divides by 128.
  localparam logic [7:0] BND_256  = 8'hff;    // Boundaries of the count.
  localparam logic [7:0] BND_64   = 8'h3f;
  localparam logic [7:0] BND_32   = 8'h1f;
  localparam logic [7:0] BND_16   = 8'h0f;
endpackage : tc_pkg

// ===== verilog/tc_timer1.sv
// Purpose: Second 8-bit up timer/counter with buzzer and PWM output.
// Assumes: cpu_tick and osc_tick are one-cycle enables on ref_clk.
// Notes:   Registers are reached over AXI4-Lite, one word per register.
// Summary of operation
// (RL1) Fast select 0: CPU tick divided 256..2.
// (RL2) Fast select 1: oscillator tick divided 128..1.
// (RL3) Fast select is config bit 3, reset 0.
// (RL4) Run bit low stops count, buzzer, PWM.
// (RL5) External source ignores divider and fast select.
// (RL6) External mode keeps event pin flag zero.
// (RL7) Eight-bit count register, wraps every 256.
// (RL8) Software presets count as 256 minus interval.
// (RL9) Overflow with reload copies reload into count.
// (RL10) PWM forces reload; reload and toggle bits pick boundary.
// (RL11) PWM boundary 255, 63, 31 or 15.
// (RL12) Software computes reload from boundary number.
// (RL13) Toggle output runs at half overflow rate.
// (RL14) Toggle output takes the port bit over.
// (RL15) Software keeps PWM off while buzzer used.
// (RL16) Software stops timer before reconfiguring it.
// (RL17) Overflow keeps counting and sets request flag.
// (RL18) Reload bit one enables reload outside PWM.
// (RL19) External mode counts falling pin edges.
// (RL20) PWM high while count below reload.
// (RL21) Count increments per tick, wraps at boundary.
// (RL22) Count write replaces count next cycle.
//
// Implementation choice: the AXI4-Lite register port.
module tc_timer1 import tc_pkg::*; (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Time bases from the clock generator.
  input  wire logic              cpu_tick,
  input  wire logic              osc_tick,
  // External event pin.
  input  wire logic              event_in,
  // Port bit and request flags.
  output logic                   port_bit_q,
  output logic                   port_owned_q,
  output logic                   timer_irq_flag_q,
  output logic                   timer_irq_enable_q,
  output logic                   event_pin_irq_flag_q,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic [ADDR_W-1:0] awaddr_q;     // Held write address.
  logic [7:0]        wdata_q;      // Held write byte.
  logic              wstrb_q;      // Held lane 0 strobe.
  logic [7:0]        cfg_q;        // Shared configuration register.
  logic [7:0]        mode_q;       // Timer mode register.
  logic [7:0]        cnt_q;        // Count register.
  logic [7:0]        rld_q;        // Reload register.
  logic [7:0]        pre_cpu_q;    // CPU tick prescaler.
  logic [7:0]        pre_osc_q;    // Oscillator tick prescaler.
  logic [2:0]        evt_q;        // Pin synchroniser and edge stage.
  logic              wr_en;        // Both halves of a write are held.
  logic [9:0]        wr_idx;       // Word index of the write.
  logic [9:0]        rd_idx;       // Word index of the read.
  logic              cnt_wr;       // Software writes the count.
  logic              run;          // Timer is enabled.
  logic              ext;          // External event mode.
  logic              pwm;          // PWM mode.
  logic              tog;          // Buzzer mode, only outside PWM.
  logic              fall;         // Falling edge seen on the pin.
  logic              tick;         // Selected count tick.
  logic              reload_on;    // Reload applies at overflow.
  logic [7:0]        bound;        // Last count before overflow.
  logic              ovf;          // Overflow in this cycle.
  logic [7:0]        cpu_mask, osc_mask;  // Divider masks for the two time bases.
  assign wr_en  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = awaddr_q[ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  assign cnt_wr = wr_en && wstrb_q && (wr_idx == IDX_CNT);
  assign run    = mode_q[MOD_RUN];
  assign ext    = mode_q[MOD_EXT];
  assign pwm    = mode_q[MOD_PWM];
  assign tog    = mode_q[MOD_TOG] && !pwm;
  // The first synchroniser stage evt_q[0] feeds only evt_q[1].
  assign fall   = !evt_q[1] && evt_q[2];
  // ==========================================================================
  // Tick selection.
  // ==========================================================================
  // Prescalers run free so a rate change needs no restart; the cost is that
  // the first tick after a change may come early.
  assign cpu_mask = CPU_MASK >> mode_q[MOD_RATE +: 3];
  assign osc_mask = OSC_MASK >> mode_q[MOD_RATE +: 3];
  always_comb begin
    if (!run) begin
      tick = 1'b0;                                       // RL4
    end else if (ext) begin
      tick = fall;                                       // RL5 RL19
    end else if (cfg_q[CFG_FAST]) begin
      tick = osc_tick && ((pre_osc_q & osc_mask) == osc_mask);  // RL2
    end else begin
      tick = cpu_tick && ((pre_cpu_q & cpu_mask) == cpu_mask);  // RL1
    end
  end
  // PWM forces reload and reuses the reload and toggle bits as a size.
  assign reload_on = pwm || mode_q[MOD_ALOAD];           // RL10 RL18
  // Outside PWM the count always runs the full eight bits.
  always_comb begin
    case ({pwm, mode_q[MOD_ALOAD], mode_q[MOD_TOG]})     // RL11
      3'b101:  bound = BND_64;
      3'b110:  bound = BND_32;
      3'b111:  bound = BND_16;
      default: bound = BND_256;                          // RL7
    endcase
  end
  assign ovf = tick && (cnt_q == bound);
  // Prescaler counters advance on their own time base.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_cpu_q <= 8'h00;
      pre_osc_q <= 8'h00;
    end else begin
      if (cpu_tick) begin
        pre_cpu_q <= pre_cpu_q + 8'h01;
      end
      if (osc_tick) begin
        pre_osc_q <= pre_osc_q + 8'h01;
      end
    end
  end
  // Pin synchroniser plus one stage for edge detection.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_q <= 3'h7;
    end else begin
      evt_q <= {evt_q[1:0], event_in};
    end
  end
  // ==========================================================================
  // Counter.
  // ==========================================================================
  // A software write wins over counting so a preset is never lost.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= CNT_RST;
    end else if (cnt_wr) begin
      cnt_q <= wdata_q;                                  // RL22
    end else if (ovf) begin
      cnt_q <= reload_on ? rld_q : 8'h00;                // RL9 RL21
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;                            // RL21
    end
  end
  // ==========================================================================
  // Port bit.
  // ==========================================================================
  // Buzzer toggles per overflow; PWM compares; a stopped timer drives low.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_bit_q   <= 1'b0;
      port_owned_q <= 1'b0;
    end else begin
      port_owned_q <= tog || pwm;                        // RL14
      if (!run) begin
        port_bit_q <= 1'b0;                              // RL4
      end else if (pwm) begin
        port_bit_q <= cnt_q < rld_q;                     // RL20
      end else if (tog && ovf) begin
        port_bit_q <= !port_bit_q;                       // RL13
      end else if (!tog) begin
        port_bit_q <= 1'b0;
      end
    end
  end
  // ==========================================================================
  // Registers and flags.
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q  <= CFG_RST;                                 // RL3
      mode_q <= MOD_RST;
      rld_q  <= RLD_RST;
    end else if (wr_en && wstrb_q) begin
      if (wr_idx == IDX_CFG) cfg_q <= wdata_q;           // RL3
      if (wr_idx == IDX_MOD) mode_q <= wdata_q;
      if (wr_idx == IDX_RLD) rld_q <= wdata_q;
    end
  end
  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_irq_flag_q     <= 1'b0;
      timer_irq_enable_q   <= 1'b0;
      event_pin_irq_flag_q <= 1'b0;
    end else begin
      if (wr_en && wstrb_q && wr_idx == IDX_IRQ) begin
        timer_irq_enable_q <= wdata_q[IRQ_EN];
      end
      if (ovf) begin
        timer_irq_flag_q <= 1'b1;                        // RL17
      end else if (wr_en && wstrb_q && wr_idx == IDX_IRQ) begin
        timer_irq_flag_q <= wdata_q[IRQ_FLAG];
      end
      if (ext) begin
        event_pin_irq_flag_q <= 1'b0;                    // RL6
      end else if (fall) begin
        event_pin_irq_flag_q <= 1'b1;
      end else if (wr_en && wstrb_q && wr_idx == IDX_IRQ) begin
        event_pin_irq_flag_q <= wdata_q[IRQ_PIN];
      end
    end
  end
  // ==========================================================================
  // AXI4-Lite write channels.
  // ==========================================================================
  // Ready high means the holding slot is empty; each half is taken alone.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      awaddr_q      <= '0;
      wdata_q       <= 8'h00;
      wstrb_q       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata[7:0];
        wstrb_q      <= s_axi_wstrb[0];
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == IDX_CFG || wr_idx == IDX_MOD || wr_idx == IDX_CNT ||
                         wr_idx == IDX_RLD || wr_idx == IDX_IRQ) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // ==========================================================================
  // AXI4-Lite read channels.
  // ==========================================================================
  // The reload register is write only and reads as zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OK;
      case (rd_idx)
        IDX_CFG: s_axi_rdata <= {24'h0, cfg_q};
        IDX_MOD: s_axi_rdata <= {24'h0, mode_q};
        IDX_CNT: s_axi_rdata <= {24'h0, cnt_q};
        IDX_RLD: s_axi_rdata <= 32'h0000_0000;
        IDX_IRQ: s_axi_rdata <= {29'h0, event_pin_irq_flag_q, timer_irq_flag_q, timer_irq_enable_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ==========================================================================
  // Assertions.
  // ==========================================================================
  property p_cpu_src;
    @(posedge ref_clk) disable iff (rst) (tick && !ext && !cfg_q[CFG_FAST]) |-> cpu_tick;
  endproperty
  a_cpu_src: assert property (p_cpu_src) else $error("tick without cpu base"); // RL1
  property p_osc_src;
    @(posedge ref_clk) disable iff (rst) (tick && !ext && cfg_q[CFG_FAST]) |-> osc_tick;
  endproperty
  a_osc_src: assert property (p_osc_src) else $error("tick without osc base"); // RL2
  property p_ext_src;
    @(posedge ref_clk) disable iff (rst) (tick && ext) |-> (!evt_q[1] && evt_q[2]);
  endproperty
  a_ext_src: assert property (p_ext_src) else $error("event tick without edge"); // RL19
  property p_stop;
    @(posedge ref_clk) disable iff (rst) (!run && !cnt_wr) |=> ($stable(cnt_q) && !port_bit_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer moved"); // RL4
  property p_ovf_irq;
    @(posedge ref_clk) disable iff (rst) ovf |=> timer_irq_flag_q;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow lost"); // RL17
  property p_reload;
    @(posedge ref_clk) disable iff (rst) (ovf && reload_on && !cnt_wr) |=> cnt_q == $past(rld_q);
  endproperty
  a_reload: assert property (p_reload) else $error("reload not copied"); // RL9
  property p_wrap;
    @(posedge ref_clk) disable iff (rst) (ovf && !reload_on && !cnt_wr) |=> cnt_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to zero"); // RL7
  property p_pwm;
    @(posedge ref_clk) disable iff (rst) (run && pwm) |=> port_bit_q == ($past(cnt_q) < $past(rld_q));
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level wrong"); // RL20
  property p_pin_flag;
    @(posedge ref_clk) disable iff (rst) ext |=> !event_pin_irq_flag_q;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag in event mode"); // RL6
  property p_cnt_wr;
    @(posedge ref_clk) disable iff (rst) cnt_wr |=> cnt_q == $past(wdata_q);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost"); // RL22
  property p_toggle;
    @(posedge ref_clk) disable iff (rst) (run && tog && ovf) |=> port_bit_q != $past(port_bit_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("buzzer missed toggle"); // RL13
  property p_pwm_bound;
    @(posedge ref_clk) disable iff (rst) (tick && pwm && &mode_q[MOD_TOG +: 2]) |-> (ovf == (cnt_q == 8'h0f));
  endproperty
  a_pwm_bound: assert property (p_pwm_bound) else $error("pwm boundary wrong"); // RL11
endmodule : tc_timer1

// ===== verif/test_timer1_counter_buzzer_pwm.sv
// Purpose: Self-checking bench for the second 8-bit timer/counter.
// Assumes: AXI4-Lite byte address is four times the register index.
// Notes:   Ticks are held high for whole runs so divider counts come out exact.
module test_timer1_counter_buzzer_pwm import tc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus and observed signals.
  // ==========================================================================
  logic              ref_clk, rst, cpu_tick, osc_tick, event_in;     // Clock, reset, time bases, pin.
  logic              port_bit_q, port_owned_q;                        // Port pin and ownership.
  logic              timer_irq_flag_q, timer_irq_enable_q, event_pin_irq_flag_q;  // Flags.
  logic [ADDR_W-1:0] awaddr, araddr;                                  // Bus addresses.
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata;                                    // Bus data.
  logic [3:0]        wstrb;                                           // Byte lanes.
  logic [1:0]        bresp, rresp;                                    // Answers.
  int                n_mismatch, n_checks, cyc;                       // Report counters.
  logic [7:0]        bnd [4] = '{BND_256, BND_64, BND_32, BND_16};    // PWM boundaries.

  tc_timer1 uut (
    .ref_clk(ref_clk), .rst(rst), .cpu_tick(cpu_tick), .osc_tick(osc_tick), .event_in(event_in),
    .port_bit_q(port_bit_q), .port_owned_q(port_owned_q), .timer_irq_flag_q(timer_irq_flag_q),
    .timer_irq_enable_q(timer_irq_enable_q), .event_pin_irq_flag_q(event_pin_irq_flag_q),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // ==========================================================================
  // Clock and hang guard.
  // ==========================================================================
  // The 8 ns clock; the whole run needs about 4k cycles, so 60k means a hang.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  // Counts one comparison; case inequality keeps unknowns from matching.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Write one register; address and data are released separately when taken.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OK);
    logic done;
    done = 1'b0;
    awaddr  <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    // One idle edge, so a following call never re-raises bready in this step.
    @(posedge ref_clk);
  endtask : wr

  // Read one register and compare the whole word with the zero-extended byte, and the answer code.
  task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er = RESP_OK);
    logic done;
    done = 1'b0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        chk("rdata", {24'h0, e}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    // One idle edge, so a following call never re-raises rready in this step.
    @(posedge ref_clk);
  endtask : rd

  // Holds one time base high for n edges, then lets the result settle.
  task automatic tk(input bit osc, input int n);
    if (osc) osc_tick <= 1'b1;
    else cpu_tick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    osc_tick <= 1'b0;
    cpu_tick <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : tk

  // One falling then rising edge, each level long enough for the synchroniser.
  task automatic ev_pulse();
    event_in <= 1'b0;
    repeat (5) @(posedge ref_clk);
    event_in <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask : ev_pulse

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  // Reset values, a hole in the map, write-only reload and a stopped counter.
  task automatic t_regs();
    rd(IDX_CFG, 8'h00);
    rd(IDX_MOD, 8'h00);
    rd(IDX_CNT, 8'h00);
    rd(IDX_IRQ, 8'h00);
    chk("port_owned", 0, port_owned_q);
    rd(10'h0d9, 8'h00, RESP_ERR);
    wr(10'h0d9, 8'hff, RESP_ERR);
    wr(IDX_CFG, 8'h08);
    rd(IDX_CFG, 8'h08);
    wr(IDX_RLD, 8'h33);
    rd(IDX_RLD, 8'h00);
    wr(IDX_CNT, 8'h5a);
    rd(IDX_CNT, 8'h5a);
    tk(1, 8);
    rd(IDX_CNT, 8'h5a);
    wr(IDX_IRQ, 8'h01);
    chk("irq_enable", 1, timer_irq_enable_q);
  endtask : t_regs

  // Every divider code of both sources: 256 or 128 ticks give 1 << code steps.
  task automatic t_div();
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 8; c++) begin
        wr(IDX_MOD, 8'h00);
        wr(IDX_CFG, f[0] ? 8'h08 : 8'h00);
        wr(IDX_CNT, 8'h00);
        wr(IDX_MOD, 8'h80 | (c[7:0] << 4));
        tk(f[0], f[0] ? 128 : 256);
        rd(IDX_CNT, 8'h01 << c);
      end
    end
  endtask : t_div

  // Overflow with and without reload; the flag sets either way.
  task automatic t_ovf();
    wr(IDX_IRQ, 8'h00);
    wr(IDX_CNT, 8'hfe);
    wr(IDX_RLD, 8'h40);
    wr(IDX_MOD, 8'hf4);
    tk(1, 2);
    chk("irq_flag", 1, timer_irq_flag_q);
    rd(IDX_CNT, 8'h40);
    wr(IDX_IRQ, 8'h00);
    wr(IDX_MOD, 8'hf0);
    wr(IDX_CNT, 8'hff);
    tk(1, 1);
    rd(IDX_CNT, 8'h00);
    chk("irq_flag", 1, timer_irq_flag_q);
  endtask : t_ovf

  // Buzzer: the pin flips on each overflow and drops when the timer stops.
  task automatic t_tog();
    wr(IDX_CNT, 8'hff);
    wr(IDX_MOD, 8'hf2);
    chk("port_owned", 1, port_owned_q);
    chk("port_bit", 0, port_bit_q);
    tk(1, 1);
    chk("port_bit", 1, port_bit_q);
    wr(IDX_CNT, 8'hff);
    tk(1, 1);
    chk("port_bit", 0, port_bit_q);
    wr(IDX_CNT, 8'hff);
    tk(1, 1);
    chk("port_bit", 1, port_bit_q);
    wr(IDX_MOD, 8'h72);
    repeat (2) @(posedge ref_clk);
    chk("port_bit", 0, port_bit_q);
    tk(1, 4);
    rd(IDX_CNT, 8'h00);
  endtask : t_tog

  // PWM: each boundary code wraps to the reload value, pin high below it.
  task automatic t_pwm();
    for (int k = 0; k < 4; k++) begin
      wr(IDX_MOD, 8'h00);
      wr(IDX_IRQ, 8'h00);
      wr(IDX_CNT, bnd[k]);
      wr(IDX_RLD, 8'h05);
      wr(IDX_MOD, 8'hf1 | (k[7:0] << 1));
      tk(1, 1);
      rd(IDX_CNT, 8'h05);
      chk("irq_flag", 1, timer_irq_flag_q);
      chk("port_bit", 0, port_bit_q);
      wr(IDX_CNT, 8'h04);
      repeat (2) @(posedge ref_clk);
      chk("port_bit", 1, port_bit_q);
    end
  endtask : t_pwm

  // Event counting ignores both time bases and keeps the pin flag clear.
  task automatic t_ext();
    wr(IDX_MOD, 8'h00);
    wr(IDX_IRQ, 8'h00);
    ev_pulse();
    chk("pin_flag", 1, event_pin_irq_flag_q);
    wr(IDX_IRQ, 8'h00);
    wr(IDX_CNT, 8'h00);
    wr(IDX_MOD, 8'hf8);
    cpu_tick <= 1'b1;
    osc_tick <= 1'b1;
    repeat (3) ev_pulse();
    cpu_tick <= 1'b0;
    osc_tick <= 1'b0;
    rd(IDX_CNT, 8'h03);
    chk("pin_flag", 0, event_pin_irq_flag_q);
  endtask : t_ext

  // ==========================================================================
  // Verdict and main sequence.
  // ==========================================================================
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {cpu_tick, osc_tick, awvalid, wvalid, bready, arvalid, rready} = '0;
    {n_mismatch, n_checks, cyc} = '0;
    rst = 1'b1;
    event_in = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("port_bit", 0, port_bit_q);
    t_regs();
    t_div();
    t_ovf();
    t_tog();
    t_pwm();
    t_ext();
    give_verdict();
  end
endmodule : test_timer1_counter_buzzer_pwm
